// >>> common/ring_fetch_defs.vh
`ifndef RING_FETCH_DEFS_VH
`define RING_FETCH_DEFS_VH
`define ADDR_TAIL        16'h2030
`define ADDR_HEAD        16'h2034
`define ADDR_START       16'h2038
`define ADDR_LENGTH      16'h203C
`define ADDR_RESUME      16'h2134
`define RESET_WORD       32'h00000000
`define WRAP_HI          31
`define WRAP_LO          21
`define OFFS_HI          20
`define OFFS_LO          3
`define START_LO         12
`define LEN_HI           20
`define LEN_LO           12
`define ENABLE_BIT       0
`define REPORT_HI        2
`define REPORT_LO        1
`define RESUME_VALID_BIT 0
`define REPORT_OFF       2'h0
`define REPORT_64K       2'h1
`define REPORT_128K      2'h3
`define REPORT_64K_BIT   16
`define REPORT_128K_BIT  17
`endif

// >>> hw/report_boundary.v
`timescale 1ns/1ps
`include "ring_fetch_defs.vh"
// Flags when the head offset crosses the selected report boundary.
module report_boundary
(
  // Head movement
  input  wire [17:0] oldOffset,
  input  wire [17:0] newOffset,
  input  wire        headMoved,
  // Selection
  input  wire [1:0]  reportMode,
  // Result
  output reg         crossed
);
  // A wrap back to offset zero lands on a boundary as well
  wire wrapped = newOffset < oldOffset;

  // Offsets are quadword units; byte bit 16 is quadword bit 13
  always @*
  begin
    crossed = 1'b0;
    if (headMoved)
    begin
      case (reportMode)
        `REPORT_64K:  crossed = wrapped ||
                                (oldOffset[`REPORT_64K_BIT-3] != newOffset[`REPORT_64K_BIT-3]);
        `REPORT_128K: crossed = wrapped ||
                                (oldOffset[`REPORT_128K_BIT-3] != newOffset[`REPORT_128K_BIT-3]);
        default:      crossed = 1'b0;
      endcase
    end
  end
endmodule // report_boundary

// >>> hw/ring_buffer_command_fetch_regs.v
// Function
// [R1] Four 32-bit ring description registers
// [R2] Software tail points past last quadword
// [R3] Software fills sequentially, may wrap
// [R4] Software pads to quadword boundary
// [R5] Software programs head before enabling
// [R6] Enable accepted empty or non-empty
// [R7] Eleven-bit head wrap counter, rolls over
// [R8] Start write clears head and wraps
// [R9] Ring fetches use global translation table
// [R10] Length is pages minus one
// [R11] Report head to status page on crossing
// [R12] Report field decode 0,1,3; 2 reserved
// [R13] Resume pointer holds address bits 31:3
// [R14] Resume valid cleared when adopted
// [R15] Fetch at head, advance, wrap at length
// [R16] Stop when empty, resume on tail move
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`include "ring_fetch_defs.vh"
module ring_buffer_command_fetch_regs
(
  // Clock and reset
  input  wire        clock,
  input  wire        rst,
  // Register port
  input  wire [15:0] regAddr,
  input  wire [31:0] regWrData,
  input  wire        regWrite,
  input  wire        regRead,
  output reg  [31:0] regRdData,
  // Instruction fetch
  output wire        fetchValid,
  output reg  [31:0] fetchAddr,
  output wire        fetchGlobalTable,
  input  wire        fetchReady,
  // Pre-emption request from the parser
  input  wire        preemptTake,
  // Head report to status page
  output reg         reportValid,
  output reg  [31:0] reportData,
  input  wire        reportReady
);
  // One-hot sequencer states
  localparam IDLE   = 3'b001;
  localparam FETCH  = 3'b010;
  localparam REPORT = 3'b100;

  // Ring description registers
  reg  [31:0] tail_reg;     // [R1]
  reg  [31:0] head_reg;
  reg  [31:0] start_reg;
  reg  [31:0] length_reg;
  reg  [31:0] resume_reg;
  reg  [2:0]  state_reg;

  // Next values
  reg  [31:0] tail_next;
  reg  [31:0] head_next;
  reg  [31:0] start_next;
  reg  [31:0] length_next;
  reg  [31:0] resume_next;
  reg  [2:0]  state_next;

  // Output next values
  reg  [31:0] regRdData_next;
  reg         reportValid_next;
  reg  [31:0] reportData_next;
  reg  [31:0] fetchAddr_next;

  // Register port decode
  wire        hitTail   = regAddr == `ADDR_TAIL;
  wire        hitHead   = regAddr == `ADDR_HEAD;
  wire        hitStart  = regAddr == `ADDR_START;
  wire        hitLength = regAddr == `ADDR_LENGTH;
  wire        hitResume = regAddr == `ADDR_RESUME;

  // Writes to unmapped offsets decode to nothing and are ignored
  wire        wrTail    = regWrite && hitTail;
  wire        wrHead    = regWrite && hitHead;
  wire        wrStart   = regWrite && hitStart;
  wire        wrLength  = regWrite && hitLength;
  wire        wrResume  = regWrite && hitResume;

  // Write data fields
  wire [10:0] wdWrap    = regWrData[`WRAP_HI:`WRAP_LO];
  wire [17:0] wdOffs    = regWrData[`OFFS_HI:`OFFS_LO];
  wire [19:0] wdStart   = regWrData[31:`START_LO];
  wire [8:0]  wdPages   = regWrData[`LEN_HI:`LEN_LO];
  wire [1:0]  wdReport  = regWrData[`REPORT_HI:`REPORT_LO];
  wire        wdEnable  = regWrData[`ENABLE_BIT];
  wire [28:0] wdPointer = regWrData[31:`OFFS_LO];
  wire        wdValid   = regWrData[`RESUME_VALID_BIT];

  // Ring state views
  wire        ringOn     = length_reg[`ENABLE_BIT];
  wire [17:0] headOffs   = head_reg[`OFFS_HI:`OFFS_LO];
  wire [17:0] tailOffs   = tail_reg[`OFFS_HI:`OFFS_LO];
  wire [10:0] wrapCount  = head_reg[`WRAP_HI:`WRAP_LO];
  wire [1:0]  reportSel  = length_reg[`REPORT_HI:`REPORT_LO];
  wire [8:0]  pagesLess  = length_reg[`LEN_HI:`LEN_LO];
  wire [17:0] resumeOffs = resume_reg[`OFFS_HI:`OFFS_LO];
  wire        resumeSet  = resume_reg[`RESUME_VALID_BIT];

  // Head arithmetic
  // Head offset counts quadwords; byte bits 2:0 are always zero
  // Pages minus one, in quadwords: (n+1)*512 - 1
  wire [17:0] lastOffs  = {pagesLess, 9'h1FF};                      // [R10]
  wire        notEmpty  = headOffs != tailOffs;                    // [R16]
  wire        atEnd     = headOffs == lastOffs;
  wire [17:0] nextOffs  = atEnd ? 18'h00000 : headOffs + 18'h00001; // [R15]
  wire [10:0] nextWrap  = atEnd ? wrapCount + 11'h001 : wrapCount;  // [R7]
  wire [31:0] nextHead  = {nextWrap, nextOffs, 3'h0};
  wire [31:0] adoptHead = {wrapCount, resumeOffs, 3'h0};

  // Handshake qualifiers
  wire        fetching  = state_reg == FETCH;
  wire        advance   = fetching && fetchReady;
  wire        adopt     = preemptTake && resumeSet;
  // Report flag from the boundary checker below
  wire        crossed;
  wire        newReport = advance && crossed;

  // Crossing test lives in its own module so both report modes share it
  report_boundary boundary
  (
    .oldOffset  (headOffs),
    .newOffset  (nextOffs),
    .headMoved  (advance),
    .reportMode (reportSel),
    .crossed    (crossed)
  );

  // Only the global table is ever used for ring fetches
  assign fetchGlobalTable = 1'b1; // [R9]
  assign fetchValid       = fetching;

  // Tail: software only; wrap bits are not kept
  always @*
  begin
    tail_next = tail_reg;
    if (wrTail)
      tail_next = {11'h000, wdOffs, 3'h0};
  end

  // Start: page aligned, low bits read back as zero
  always @*
  begin
    start_next = start_reg;
    if (wrStart)
      start_next = {wdStart, 12'h000};
  end

  // Only pages, report mode and enable are kept
  // Reserved code 2 is stored but never reports
  always @*
  begin
    length_next = length_reg;
    if (wrLength)
      length_next = {11'h000, wdPages, 9'h000, wdReport, wdEnable}; // [R12]
  end

  // Adoption wins over a same-cycle software write of the valid bit
  always @*
  begin
    resume_next = resume_reg;
    if (wrResume)
      resume_next = {wdPointer, 2'h0, wdValid}; // [R13]
    if (adopt)
      resume_next[`RESUME_VALID_BIT] = 1'b0; // [R14]
  end

  // Hardware moves first; a software write in the same cycle wins
  always @*
  begin
    head_next = head_reg;
    if (advance)
      head_next = nextHead;
    // Pre-emption jumps to the pending pointer, wrap count kept
    if (adopt)
      head_next = adoptHead;
    if (wrHead)
      head_next = {wdWrap, wdOffs, 3'h0};
    if (wrStart)
      head_next = `RESET_WORD; // [R8]
  end

  // Built from next values so the registered address matches the head
  always @*
  begin
    fetchAddr_next = {start_next[31:`START_LO], 12'h000}
                     + {11'h000, head_next[`OFFS_HI:`OFFS_LO], 3'h0};
  end

  // Report stays up until the status page write is taken
  always @*
  begin
    reportValid_next = reportValid;
    if (newReport)
      reportValid_next = 1'b1; // [R11]
    else if (reportReady)
      reportValid_next = 1'b0;
  end

  // Holds the head value that crossed until the next report
  always @*
  begin
    reportData_next = reportData;
    if (newReport)
      reportData_next = nextHead; // [R11]
  end

  // Unmapped and idle cycles read as zero
  always @*
  begin
    regRdData_next = `RESET_WORD;
    if (regRead)
    begin
      case (regAddr)
        `ADDR_TAIL:   regRdData_next = tail_reg;
        `ADDR_HEAD:   regRdData_next = head_reg;
        `ADDR_START:  regRdData_next = start_reg;
        `ADDR_LENGTH: regRdData_next = length_reg;
        `ADDR_RESUME: regRdData_next = resume_reg;
        default:      regRdData_next = `RESET_WORD;
      endcase
    end
  end

  // One fetch per visit to FETCH; IDLE re-checks empty and enable
  // Disabling mid-fetch drops the request; the head still moves if fetchReady comes in that cycle
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      IDLE:
      begin
        if (ringOn && notEmpty && !adopt) // [R6]
          state_next = FETCH;
      end
      FETCH:
      begin
        if (!ringOn)
          state_next = IDLE;
        else if (newReport)               // [R11]
          state_next = REPORT;
        else if (advance)
          state_next = IDLE;              // [R16]
      end
      REPORT:
      begin
        if (reportReady)
          state_next = IDLE;
      end
      default:
        state_next = IDLE;
    endcase
  end

  // State register
  always @(posedge clock)
  begin
    if (rst)
      state_reg <= IDLE;
    else
      state_reg <= state_next;
  end

  // Every register except state_reg clears to zero on reset; state_reg resets to IDLE
  always @(posedge clock)
  begin
    if (rst)
      tail_reg <= `RESET_WORD;
    else
      tail_reg <= tail_next;
  end

  always @(posedge clock)
  begin
    if (rst)
      head_reg <= `RESET_WORD;
    else
      head_reg <= head_next;
  end

  always @(posedge clock)
  begin
    if (rst)
      start_reg <= `RESET_WORD;
    else
      start_reg <= start_next;
  end

  always @(posedge clock)
  begin
    if (rst)
      length_reg <= `RESET_WORD;
    else
      length_reg <= length_next;
  end

  always @(posedge clock)
  begin
    if (rst)
      resume_reg <= `RESET_WORD;
    else
      resume_reg <= resume_next;
  end

  // Read data stands for one cycle only
  always @(posedge clock)
  begin
    if (rst)
      regRdData <= `RESET_WORD;
    else
      regRdData <= regRdData_next;
  end

  // Address is held steady while a fetch waits, unless head or start is written or a resume is adopted
  always @(posedge clock)
  begin
    if (rst)
      fetchAddr <= `RESET_WORD;
    else
      fetchAddr <= fetchAddr_next;
  end

  always @(posedge clock)
  begin
    if (rst)
      reportValid <= 1'b0;
    else
      reportValid <= reportValid_next;
  end

  always @(posedge clock)
  begin
    if (rst)
      reportData <= `RESET_WORD;
    else
      reportData <= reportData_next;
  end
endmodule // ring_buffer_command_fetch_regs

// >>> tb/ring_chk_properties.sv
`timescale 1ns/1ps
`include "ring_fetch_defs.vh"
module ring_chk
(
  // Watched ports
  input wire        clock, rst, regWrite, regRead, fetchValid, fetchGlobalTable,
  input wire        fetchReady, reportValid, reportReady,
  input wire [15:0] regAddr,
  input wire [31:0] regRdData, fetchAddr
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  // Only valid while the ring is off
  sequence sStartHead;
    regWrite && regAddr == `ADDR_START ##2 regRead && regAddr == `ADDR_HEAD;
  endsequence
  AST_TABLE: assert property (fetchGlobalTable) else $error("local table");
  AST_CLEAR: assert property (sStartHead |=> regRdData == 32'h0) else $error("head kept");
  AST_NOMAP: assert property (regRead && !regAddr |=> regRdData == 32'h0) else $error("map");
  AST_IDLE: assert property (!$past(regRead) |-> regRdData == 32'h0) else $error("data");
  AST_HOLD: assert property (fetchValid && !fetchReady && !regWrite |=>
    fetchValid && $stable(fetchAddr)) else $error("fetch dropped");
  AST_GAP: assert property (fetchValid && fetchReady |=> !fetchValid) else $error("gap");
  AST_STEP: assert property (fetchValid && fetchReady |=>
    fetchAddr == $past(fetchAddr) + 32'h8 || fetchAddr[11:0] == 12'h0) else $error("step");
  AST_REP: assert property (reportValid && !reportReady |=> reportValid) else $error("rep");
endmodule // ring_chk
bind ring_buffer_command_fetch_regs ring_chk chk (.*);

// >>> tb/mem_model.sv
`timescale 1ns/1ps
module mem_model
(
  input wire clock, fetchValid, reportValid,
  output reg fetchReady = 1'b0, reportReady = 1'b0
);
  reg slowTurn = 1'b0;
  // Ready can only rise on alternate cycles, so held requests get seen
  always @(posedge clock)
  begin
    slowTurn <= !slowTurn;
    fetchReady <= fetchValid && !fetchReady && slowTurn;
    reportReady <= reportValid && !reportReady && !slowTurn;
  end
endmodule // mem_model

// >>> tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  reg         clock = 1'b0, rst = 1'b1, regWrite = 1'b0, regRead = 1'b0, preemptTake = 1'b0;
  reg  [15:0] regAddr = 16'h0;
  reg  [31:0] regWrData = 32'h0;
  wire [31:0] regRdData, fetchAddr, reportData;
  wire        fetchValid, fetchGlobalTable, fetchReady, reportValid, reportReady;
  reg  [31:0] lastReport = 32'h0;
  integer     errCount = 0, totalChecks = 0, reports = 0, m;
  ring_buffer_command_fetch_regs dut (.*);
  mem_model mem (.*);
  initial forever #5 clock = ~clock;
  always @(posedge clock)
  begin
    reports <= reports + (reportValid && reportReady);
    if (reportValid && reportReady)
      lastReport <= reportData;
  end
  task chk(input [31:0] s, input [31:0] e);
    totalChecks = totalChecks + 1;
    errCount = errCount + (s !== e);
    if (s !== e)
      $display("[ERR] %0t got %h want %h", $time, s, e);
  endtask
  // Sampled 1 ns after the edge so read data has settled
  task bus(input w, input [15:0] a, input [31:0] d);
    {regWrite, regRead, regAddr, regWrData} <= {w, !w, a, d};
    @(posedge clock);
    {regWrite, regRead} <= 2'b00;
    #1;
    if (!w)
      chk(regRdData, d);
    @(posedge clock);
  endtask
  task wrap_up(input integer late);
    errCount = errCount + late;
    $display("checks %0d errors %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task t_regs;
    for (m = 0; m < 4; m = m + 1)
      bus(0, 16'(16'h2030 + 4 * m), 32'h0);
    bus(0, 16'h2134, 32'h0);
    bus(1, 16'h0, 32'hFFFFFFFF);
    bus(0, 16'h0, 32'h0);
    bus(1, 16'h2034, 32'hFFFFFFFF);
    bus(0, 16'h2034, 32'hFFFFFFF8);
    bus(1, 16'h203C, 32'hFFFFFFFE);
    bus(0, 16'h203C, 32'h001FF006);
    bus(1, 16'h2038, 32'h00010000);
    bus(0, 16'h2034, 32'h0);
    $display("regs done");
  endtask
  task t_ring;
    bus(1, 16'h203C, 32'h1);
    bus(1, 16'h2030, 32'h20);
    repeat (40) @(posedge clock);
    chk(fetchAddr, 32'h00010020);
    for (m = 0; m < 4; m = m + 1)
    begin
      bus(1, 16'h203C, 32'h0);
      bus(1, 16'h2034, m == 3 ? 32'hFFE00FF8 : 32'hFF8);
      bus(1, 16'h2030, 32'h8);
      bus(1, 16'h203C, 32'(2 * m + 1));
      repeat (20) @(posedge clock);
      bus(0, 16'h2034, m == 3 ? 32'h8 : 32'h00200008);
      chk(reports, (m + 1) / 2);
      chk(lastReport, m == 3 ? 32'h0 : (m > 0 ? 32'h00200000 : 32'h0));
    end
    $display("ring done");
  endtask
  task t_pre;
    bus(1, 16'h203C, 32'h0);
    bus(1, 16'h2134, 32'hFFFFFFFF);
    bus(0, 16'h2134, 32'hFFFFFFF9);
    preemptTake <= 1'b1;
    @(posedge clock);
    preemptTake <= 1'b0;
    @(posedge clock);
    bus(0, 16'h2034, 32'h001FFFF8);
    bus(0, 16'h2134, 32'hFFFFFFF8);
    $display("resume done");
  endtask
  initial
  begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    t_regs;
    t_ring;
    t_pre;
    wrap_up(0);
  end
  initial
    #100000 wrap_up(1);
endmodule // testbench
